/* hw/mtn_consts.vh */
// constants for the motion module mode and hold-time control
// assumes a 125 MHz clock and analog pins digitised in 10 mV codes
// Notes on behaviour
// - at reset release or sleep exit, a level above 2.5 V selects serial mode
// - a level from 0 V to 1.8 V selects hardware mode and sensitivity input
// - serial link is 9600 bps, 8 data bits, no parity, 1 stop bit
// - motion output, light gate and sleep work alike in both modes
// - in serial mode pin 5 is reset input or motion output, default reset
// - delay input sets motion hold from 2 seconds up to 15 minutes
// - delay table: 0 V gives 2 s up to 1.8 V giving 15 min
// - sensitivity is raised for a while after each detection
// - motion output low while reporting, driven high otherwise
// - light below 1.0 V blocks new assertions; a running hold completes
// - sleep low stops detection and forces motion output inactive
// - after reset wait about 20 s, motion output inactive meanwhile
`ifndef MTN_CONSTS_VH
`define MTN_CONSTS_VH
`define MTN_CLK_HZ      125000000
`define MTN_BAUD        9600
`define MTN_BAUD_CYCLES (`MTN_CLK_HZ / `MTN_BAUD)
`define MTN_TICK_CYCLES `MTN_CLK_HZ
`define MTN_STAB_S      20
`define MTN_BOOST_S     10
`define MTN_BOOST_STEP  8'h14
`define MTN_LVL_SERIAL  8'hfa
`define MTN_LVL_HW_MAX  8'hb4
`define MTN_LVL_LIGHT   8'h64
`define MTN_LVL_STEP    8'h14
`define MTN_HOLD_0      10'h002
`define MTN_HOLD_1      10'h005
`define MTN_HOLD_2      10'h00a
`define MTN_HOLD_3      10'h01e
`define MTN_HOLD_4      10'h03c
`define MTN_HOLD_5      10'h078
`define MTN_HOLD_6      10'h0b4
`define MTN_HOLD_7      10'h12c
`define MTN_HOLD_8      10'h258
`define MTN_HOLD_9      10'h384
`endif

/* hw/mtn_uart.v */
// 8N1 serial transmitter and receiver for the command link
// assumes rxd comes from a pin; tx requests come from same-clock logic
`timescale 1ns/1ps
`include "mtn_consts.vh"
module mtn_uart #(
  parameter BIT_CYCLES = `MTN_BAUD_CYCLES
) (
  input  wire       clk,
  input  wire       nrst,
  input  wire       enable,
  input  wire       rxd,
  output reg  [7:0] rx_data,
  output reg        rx_valid,
  output reg        rx_frame_err,
  input  wire [7:0] tx_data,
  input  wire       tx_valid,
  output wire       tx_ready,
  output reg        txd
);
  reg [1:0]  rx_sync;
  reg [31:0] rx_cnt;
  reg [3:0]  rx_bit;
  reg [8:0]  rx_shift;
  reg        rx_busy;
  reg [31:0] tx_cnt;
  reg [3:0]  tx_bit;
  reg [9:0]  tx_shift;

  assign tx_ready = enable & (tx_bit == 4'h0);

  always @(posedge clk) begin
    if (!nrst) begin
      rx_sync      <= 2'h3;
      rx_cnt       <= 32'h0;
      rx_bit       <= 4'h0;
      rx_shift     <= 9'h0;
      rx_busy      <= 1'b0;
      rx_data      <= 8'h00;
      rx_valid     <= 1'b0;
      rx_frame_err <= 1'b0;
    end else begin
      rx_sync  <= {rx_sync[0], rxd};
      rx_valid <= 1'b0;
      if (!enable) begin
        rx_busy <= 1'b0;
      end else if (!rx_busy) begin
        if (!rx_sync[1]) begin
          // first sample lands mid start bit
          rx_busy <= 1'b1;
          rx_cnt  <= BIT_CYCLES / 2;
          rx_bit  <= 4'h0;
        end
      end else if (rx_cnt != 32'h0) begin
        rx_cnt <= rx_cnt - 32'h1;
      end else begin
        rx_cnt   <= BIT_CYCLES - 1;
        rx_bit   <= rx_bit + 4'h1;
        rx_shift <= {rx_sync[1], rx_shift[8:1]};
        if (rx_bit == 4'h0 && rx_sync[1]) begin
          rx_busy <= 1'b0;
        end else if (rx_bit == 4'h9) begin
          rx_busy      <= 1'b0;
          rx_data      <= rx_shift[8:1];
          rx_valid     <= rx_sync[1];
          rx_frame_err <= ~rx_sync[1];
        end
      end
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      tx_cnt   <= 32'h0;
      tx_bit   <= 4'h0;
      tx_shift <= 10'h3ff;
      txd      <= 1'b1;
    end else if (tx_bit == 4'h0) begin
      txd <= 1'b1;
      if (tx_valid && enable) begin
        tx_shift <= {1'b1, tx_data, 1'b0};
        // one slot past the stop bit keeps it a full bit long
        tx_bit   <= 4'hb;
        tx_cnt   <= 32'h0;
      end
    end else if (tx_cnt != 32'h0) begin
      tx_cnt <= tx_cnt - 32'h1;
    end else begin
      txd      <= tx_shift[0];
      tx_shift <= {1'b1, tx_shift[9:1]};
      tx_cnt   <= BIT_CYCLES - 1;
      tx_bit   <= tx_bit - 4'h1;
    end
  end
endmodule

/* hw/mtn_ctrl.v */
// mode selection, motion output hold and gating for the motion module
// assumes analog pins arrive as 8-bit codes of 10 mV from an outside
// converter; motion_seen is a one-cycle pulse from the detector on clk
`timescale 1ns/1ps
`include "mtn_consts.vh"
module mtn_ctrl #(
  parameter TICK_CYCLES = `MTN_TICK_CYCLES,
  parameter BIT_CYCLES  = `MTN_BAUD_CYCLES,
  parameter STAB_S      = `MTN_STAB_S,
  parameter BOOST_S     = `MTN_BOOST_S
) (
  input  wire       clk,
  input  wire       nrst,
  input  wire [7:0] sensitivity_level_input,
  input  wire [7:0] hold_time_level_input,
  input  wire [7:0] ambient_light_gate,
  input  wire       sleep_request_n,
  input  wire       rxd,
  input  wire       motion_seen,
  input  wire       cfg_pin5_strobe,
  input  wire       cfg_pin5_motion,
  input  wire       pin5_in,
  output wire       pin5_out,
  output wire       pin5_oe_n,
  output wire       txd_out,
  output wire       txd_oe_n,
  output reg        serial_mode,
  output wire       detect_enable,
  output reg  [7:0] effective_sensitivity,
  output reg        module_reset_req,
  output reg        motion_detect_n,
  output wire [7:0] rx_data,
  output wire       rx_valid,
  output wire       rx_frame_err,
  input  wire [7:0] tx_data,
  input  wire       tx_valid,
  output wire       tx_ready
);
  reg [7:0]  sens_m;
  reg [7:0]  sens_s;
  reg [7:0]  hold_lvl_m;
  reg [7:0]  hold_lvl_s;
  reg [7:0]  light_m;
  reg [7:0]  light_s;
  reg [2:0]  sleep_sync;
  reg [1:0]  p5_sync;
  reg [1:0]  boot_cnt;
  reg        boot_done;
  reg        pin5_motion;
  reg [31:0] tick_cnt;
  reg        tick;
  reg [9:0]  stab_left;
  reg [9:0]  hold_left;
  reg [9:0]  hold_sel;
  reg [9:0]  boost_left;
  wire       sleeping;
  wire       sleep_exit;
  wire       light_ok;
  wire       new_trip;

  // floor of level/0.2 V, clamped to the last entry
  function [9:0] hold_seconds;
    input [7:0] lvl;
    reg   [7:0] idx;
    begin
      idx = lvl / `MTN_LVL_STEP;
      case (idx)
        8'h00:   hold_seconds = `MTN_HOLD_0;
        8'h01:   hold_seconds = `MTN_HOLD_1;
        8'h02:   hold_seconds = `MTN_HOLD_2;
        8'h03:   hold_seconds = `MTN_HOLD_3;
        8'h04:   hold_seconds = `MTN_HOLD_4;
        8'h05:   hold_seconds = `MTN_HOLD_5;
        8'h06:   hold_seconds = `MTN_HOLD_6;
        8'h07:   hold_seconds = `MTN_HOLD_7;
        8'h08:   hold_seconds = `MTN_HOLD_8;
        default: hold_seconds = `MTN_HOLD_9;
      endcase
    end
  endfunction

  // every pin level passes two flops; multi-bit codes assumed slow
  always @(posedge clk) begin
    if (!nrst) begin
      sens_m     <= 8'h00;
      sens_s     <= 8'h00;
      hold_lvl_m <= 8'h00;
      hold_lvl_s <= 8'h00;
      light_m    <= 8'hff;
      light_s    <= 8'hff;
      sleep_sync <= 3'h7;
      p5_sync    <= 2'h3;
    end else begin
      sens_m     <= sensitivity_level_input;
      sens_s     <= sens_m;
      hold_lvl_m <= hold_time_level_input;
      hold_lvl_s <= hold_lvl_m;
      light_m    <= ambient_light_gate;
      light_s    <= light_m;
      sleep_sync <= {sleep_sync[1:0], sleep_request_n};
      p5_sync  <= {p5_sync[0], pin5_in};
    end
  end

  assign sleeping   = ~sleep_sync[1];
  assign sleep_exit = sleep_sync[1] & ~sleep_sync[2];
  assign light_ok   = (light_s >= `MTN_LVL_LIGHT);

  // mode is sampled once the pin sync has filled after reset
  always @(posedge clk) begin
    if (!nrst) begin
      boot_cnt    <= 2'h0;
      boot_done   <= 1'b0;
      serial_mode <= 1'b0;
    end else begin
      if (boot_cnt != 2'h3)
        boot_cnt <= boot_cnt + 2'h1;
      if ((boot_cnt == 2'h2) || (boot_done && sleep_exit)) begin
        boot_done   <= 1'b1;
        serial_mode <= (sens_s > `MTN_LVL_SERIAL);
      end
    end
  end

  // pin 5 function; only meaningful in serial mode
  always @(posedge clk) begin
    if (!nrst)
      pin5_motion <= 1'b0;
    else if (cfg_pin5_strobe)
      pin5_motion <= cfg_pin5_motion;
  end

  // one-second tick keeps the long counters narrow
  always @(posedge clk) begin
    if (!nrst) begin
      tick_cnt <= 32'h0;
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES - 1) begin
      tick_cnt <= 32'h0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick     <= 1'b0;
    end
  end

  // stabilisation after reset; sleep exit does not restart it
  always @(posedge clk) begin
    if (!nrst)
      stab_left <= STAB_S[9:0];
    else if (tick && stab_left != 10'h0)
      stab_left <= stab_left - 10'h1;
  end

  assign detect_enable = boot_done & ~sleeping & (stab_left == 10'h0);
  assign new_trip      = motion_seen & detect_enable;

  // hold timer; a retrigger reloads the latched hold time
  always @(posedge clk) begin
    if (!nrst) begin
      hold_left       <= 10'h0;
      hold_sel        <= `MTN_HOLD_0;
      motion_detect_n <= 1'b1;
    end else if (!detect_enable) begin
      hold_left       <= 10'h0;
      motion_detect_n <= 1'b1;
    end else if (new_trip && motion_detect_n && light_ok) begin
      hold_sel        <= hold_seconds(hold_lvl_s);
      hold_left       <= hold_seconds(hold_lvl_s);
      motion_detect_n <= 1'b0;
    end else if (new_trip && !motion_detect_n && light_ok) begin
      hold_left <= hold_sel;
    end else if (tick && !motion_detect_n) begin
      // dark gate never cuts a running hold short
      if (hold_left <= 10'h1) begin
        hold_left       <= 10'h0;
        motion_detect_n <= 1'b1;
      end else begin
        hold_left <= hold_left - 10'h1;
      end
    end
  end

  // lower code means higher sensitivity
  always @(posedge clk) begin
    if (!nrst) begin
      boost_left            <= 10'h0;
      effective_sensitivity <= 8'h00;
    end else begin
      if (new_trip)
        boost_left <= BOOST_S[9:0];
      else if (tick && boost_left != 10'h0)
        boost_left <= boost_left - 10'h1;
      if (boost_left == 10'h0)
        effective_sensitivity <= sens_s;
      else if (sens_s > `MTN_BOOST_STEP)
        effective_sensitivity <= sens_s - `MTN_BOOST_STEP;
      else
        effective_sensitivity <= 8'h00;
    end
  end

  always @(posedge clk) begin
    if (!nrst)
      module_reset_req <= 1'b0;
    else
      module_reset_req <= serial_mode & ~pin5_motion & ~p5_sync[1];
  end

  assign pin5_out  = motion_detect_n;
  assign pin5_oe_n = serial_mode & ~pin5_motion;
  assign txd_oe_n  = ~serial_mode;

  mtn_uart #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_uart (
    .clk          (clk),
    .nrst         (nrst),
    .enable       (serial_mode),
    .rxd          (rxd),
    .rx_data      (rx_data),
    .rx_valid     (rx_valid),
    .rx_frame_err (rx_frame_err),
    .tx_data      (tx_data),
    .tx_valid     (tx_valid),
    .tx_ready     (tx_ready),
    .txd          (txd_out)
  );
endmodule

/* testbench/mtn_props.sv */
// checker on the mtn_ctrl ports
// assumes 2-ff input syncs and a registered motion output
`timescale 1ns/1ps
module mtn_props (
  input logic       clk,
  input logic       nrst,
  input logic [7:0] ambient_light_gate,
  input logic       sleep_request_n,
  input logic       motion_seen,
  input logic       tx_valid,
  input logic       tx_ready,
  input logic       txd_out,
  input logic       txd_oe_n,
  input logic       pin5_out,
  input logic       pin5_oe_n,
  input logic       serial_mode,
  input logic       detect_enable,
  input logic       module_reset_req,
  input logic       motion_detect_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // pin levels reach the logic two or three edges late
  wire lit = ambient_light_gate >= 8'h64;
  AST_PIN5: assert property (
    pin5_out == motion_detect_n)
    else $error("pin 5 differs from motion output");
  AST_TRIP: assert property (
    motion_seen && detect_enable && lit && $past(lit) &&
    $past(lit, 2) && $past(lit, 3) |=> !motion_detect_n)
    else $error("accepted motion not reported");
  AST_DARK: assert property (
    motion_detect_n && !$past(lit, 2) && !$past(lit, 3)
    |=> motion_detect_n)
    else $error("motion reported while dark");
  AST_SLEEP: assert property (
    !$past(sleep_request_n, 2) && !$past(sleep_request_n, 3)
    |-> !detect_enable ##1 motion_detect_n)
    else $error("detection while asleep");
  AST_STAB: assert property ($rose(nrst) |->
    (motion_detect_n && !detect_enable) [*8])
    else $error("detection during stabilisation");
  AST_MODE: assert property (serial_mode != txd_oe_n)
    else $error("txd drive differs from mode");
  AST_HWOE: assert property (
    !serial_mode && !$past(serial_mode)
    |-> !pin5_oe_n && !module_reset_req)
    else $error("pin 5 not driven in hardware mode");
  AST_MRST: assert property ($rose(module_reset_req) |->
    serial_mode && pin5_oe_n)
    else $error("reset request outside serial reset use");
  // start bit leaves the flop one edge after the send is taken
  AST_TXST: assert property (tx_valid && tx_ready |=>
    !tx_ready ##1 (!txd_out && !tx_ready) [*8])
    else $error("no start bit after send");
  COV_TRIP: cover property ($fell(motion_detect_n));
  COV_SER: cover property ($rose(serial_mode));
  COV_TX: cover property (tx_valid && tx_ready);
endmodule
bind mtn_ctrl mtn_props u_props (
  .clk                (clk),
  .nrst               (nrst),
  .ambient_light_gate (ambient_light_gate),
  .sleep_request_n    (sleep_request_n),
  .motion_seen        (motion_seen),
  .tx_valid           (tx_valid),
  .tx_ready           (tx_ready),
  .txd_out            (txd_out),
  .txd_oe_n           (txd_oe_n),
  .pin5_out           (pin5_out),
  .pin5_oe_n          (pin5_oe_n),
  .serial_mode        (serial_mode),
  .detect_enable      (detect_enable),
  .module_reset_req   (module_reset_req),
  .motion_detect_n    (motion_detect_n)
);

/* testbench/mtn_host.sv */
// host side of the serial link, bit-timed on the module clock
// assumes BIT cycles per bit and a caller starting at a clock edge
`timescale 1ns/1ps
module mtn_host #(
  parameter int BIT = 16
) (
  input  logic clk,
  input  logic txd,
  output logic rxd
);
  initial rxd = 1'b1;
  // 8 data bits lsb first, stop bit may be spoilt on demand
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= (i < 10) ? f[i] : 1'b1;
      repeat (BIT) @(posedge clk);
    end
  endtask
  task automatic recv(output logic [7:0] d);
    while (txd !== 1'b0)
      @(posedge clk);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      d[i] = txd;
    end
  endtask
endmodule

/* testbench/motion_module_mode_and_delay_tb.sv */
// bench for mtn_ctrl: mode pick, hold table, gating, serial link
// assumes 10 cycles a second, 16 cycles a bit, 2 s settling
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    n_checks++; \
    if ((a) !== (b)) begin \
      n_errors++; \
      $display("[ERR] %0t got %0h exp %0h", $time, a, b); \
    end \
  end
module motion_module_mode_and_delay_tb;
  localparam int T = 10;
  localparam int HS [10] = '{2, 5, 10, 30, 60, 120, 180, 300, 600, 900};
  logic       clk = 0, nrst = 0, sleep_request_n = 1, motion_seen = 0;
  logic       cfg_pin5_strobe = 0, cfg_pin5_motion = 0, pin5_in = 1;
  logic       tx_valid = 0;
  logic [7:0] sensitivity_level_input = 8'h64, hold_time_level_input = 0;
  logic [7:0] ambient_light_gate = 8'hff, tx_data = 0, b;
  wire        rxd, pin5_out, pin5_oe_n, txd_out, txd_oe_n, serial_mode;
  wire        detect_enable, module_reset_req, rx_valid, rx_frame_err;
  wire        tx_ready, motion_detect_n;
  wire  [7:0] effective_sensitivity, rx_data;
  int         n_errors = 0, n_checks = 0, cyc = 0, c;
  mtn_ctrl #(.TICK_CYCLES(T), .BIT_CYCLES(16), .STAB_S(2), .BOOST_S(2))
    u_mtn_ctrl (
    .clk                     (clk),
    .nrst                    (nrst),
    .sensitivity_level_input (sensitivity_level_input),
    .hold_time_level_input   (hold_time_level_input),
    .ambient_light_gate      (ambient_light_gate),
    .sleep_request_n         (sleep_request_n),
    .rxd                     (rxd),
    .motion_seen             (motion_seen),
    .cfg_pin5_strobe         (cfg_pin5_strobe),
    .cfg_pin5_motion         (cfg_pin5_motion),
    .pin5_in                 (pin5_in),
    .pin5_out                (pin5_out),
    .pin5_oe_n               (pin5_oe_n),
    .txd_out                 (txd_out),
    .txd_oe_n                (txd_oe_n),
    .serial_mode             (serial_mode),
    .detect_enable           (detect_enable),
    .effective_sensitivity   (effective_sensitivity),
    .module_reset_req        (module_reset_req),
    .motion_detect_n         (motion_detect_n),
    .rx_data                 (rx_data),
    .rx_valid                (rx_valid),
    .rx_frame_err            (rx_frame_err),
    .tx_data                 (tx_data),
    .tx_valid                (tx_valid),
    .tx_ready                (tx_ready)
  );
  mtn_host #(.BIT(16)) u_mtn_host (.clk(clk), .txd(txd_out), .rxd(rxd));
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic tk(int n);
    repeat (n) @(posedge clk);
  endtask
  // c = cycles the motion output stayed low
  task automatic trip();
    @(posedge clk);
    motion_seen <= 1'b1;
    tk(1);
    motion_seen <= 1'b0;
    c = 0;
    tk(1);
    #1;
    while (motion_detect_n === 1'b0 && c < 12000) begin
      tk(1);
      #1;
      c++;
    end
  endtask
  task automatic boot(logic [7:0] s, logic ser);
    @(posedge clk);
    nrst <= 1'b0;
    sensitivity_level_input <= s;
    tk(3);
    nrst <= 1'b1;
    tk(5);
    #1;
    `CHK(serial_mode, ser)
    `CHK(detect_enable, 1'b0)
    trip();
    `CHK(c, 0)
    tk(22);
    #1;
    `CHK(detect_enable, 1'b1)
    $display("boot %0h done", s);
  endtask
  task automatic t_hold();
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      hold_time_level_input <= 8'(i * 20 + (i % 2) * 19);
      tk(4);
      trip();
      `CHK(c >= (HS[i] - 1) * T && c <= HS[i] * T + 1, 1'b1)
    end
    // level moves mid-hold; the latched 5 s must stand
    @(posedge clk);
    hold_time_level_input <= 8'h14;
    tk(4);
    fork
      trip();
      begin
        tk(5);
        hold_time_level_input <= 8'h00;
      end
    join
    `CHK(c >= 4 * T && c <= 5 * T + 1, 1'b1)
    $display("hold table done");
  endtask
  task automatic t_dark();
    @(posedge clk);
    ambient_light_gate <= 8'h63;
    tk(4);
    trip();
    `CHK(c, 0)
    @(posedge clk);
    ambient_light_gate <= 8'h64;
    tk(4);
    fork
      trip();
      begin
        tk(3);
        ambient_light_gate <= 8'h00;
        #1;
        `CHK(effective_sensitivity, 8'h50)
      end
    join
    `CHK(c >= T, 1'b1)
    $display("light gate done");
  endtask
  task automatic t_sleep();
    @(posedge clk);
    ambient_light_gate <= 8'hff;
    hold_time_level_input <= 8'h14;
    // let the light and hold levels clear the pin syncs first
    tk(4);
    fork
      trip();
      begin
        tk(8);
        sleep_request_n <= 1'b0;
        sensitivity_level_input <= 8'hfb;
      end
    join
    `CHK(c < 16, 1'b1)
    trip();
    `CHK(c, 0)
    @(posedge clk);
    sleep_request_n <= 1'b1;
    tk(6);
    #1;
    `CHK(serial_mode, 1'b1)
    `CHK(pin5_oe_n, 1'b1)
    @(posedge clk);
    pin5_in <= 1'b0;
    tk(4);
    #1;
    `CHK(module_reset_req, 1'b1)
    @(posedge clk);
    pin5_in <= 1'b1;
    cfg_pin5_motion <= 1'b1;
    cfg_pin5_strobe <= 1'b1;
    tk(1);
    cfg_pin5_strobe <= 1'b0;
    trip();
    `CHK(c > 0, 1'b1)
    `CHK(pin5_oe_n, 1'b0)
    $display("sleep and serial mode done");
  endtask
  task automatic t_uart();
    @(posedge clk);
    u_mtn_host.send(8'h5a, 1'b0);
    #1;
    `CHK(rx_frame_err, 1'b1)
    fork
      u_mtn_host.send(8'ha5, 1'b1);
      @(posedge clk iff rx_valid === 1'b1);
    join
    #1;
    `CHK(rx_data, 8'ha5)
    `CHK(rx_frame_err, 1'b0)
    @(posedge clk);
    tx_data <= 8'h3c;
    tx_valid <= 1'b1;
    fork
      u_mtn_host.recv(b);
      begin
        do @(posedge clk); while (tx_ready !== 1'b1);
        tx_valid <= 1'b0;
      end
    join
    `CHK(b, 8'h3c)
    $display("serial link done");
  endtask
  initial begin
    boot(8'hb4, 1'b0);
    boot(8'hfa, 1'b0);
    boot(8'hfb, 1'b1);
    boot(8'h64, 1'b0);
    t_hold();
    t_dark();
    t_sleep();
    t_uart();
    results();
  end
endmodule
